//--- gpio_defs.vh
// Constants for the two 8-bit general-purpose I/O ports
// Overview of operation
// - Direction one floats the pin; zero drives the output latch onto it.
// - After reset first port pins 4..0 are analog and read as zero.
// - Port read returns pin levels; port write updates only the output latch.
// - Port writes are read-modify-write: pins sampled, bits changed, latch stored.
// - First port bit 5 is input only; its direction bit reads one.
// - First port pin 4 also feeds timer external clock and analog channel.
// - In RC mode first port pin 6 outputs clock divided by four.
// - Second port pull-ups switch on for input pins when option bit 7 is clear.
// - A second port pull-up is off whenever that pin is an output.
// - Second port pull-ups are disabled after reset.
// - Only input pins among second port bits 7..4 join change detection.
// - Inputs compared with copy from last access; mismatches OR into flag.
// - The port-change interrupt can wake the device from sleep.
// - Any read or write of second port data refreshes the comparison copy.
// - Flag keeps being set while mismatch persists; clear needs port access.
// - Second port bit 0 is external interrupt input, edge chosen by option bit 6.
// - An enabled peripheral overrides a second port pin direction.
// - Low-voltage programming is on by default and takes second port bit 3.
`ifndef GPIO_DEFS_VH
`define GPIO_DEFS_VH
`define IDX_PORT_A      8'h05
`define IDX_PORT_B      8'h06
`define IDX_INTERRUPT_CONTROL      8'h0B
`define IDX_OPTION      8'h81
`define IDX_TRIS_A      8'h85
`define IDX_TRIS_B      8'h86
`define IDX_CONV_CFG    8'h9F
`define IDX_SYS_CFG     8'hA0
`define RST_OPTION      8'hFF
`define RST_TRIS        8'hFF
`define RST_CONV_CFG    8'h00
`define RST_INTERRUPT_CONTROL      8'h00
`define RST_SYS_CFG     8'h01
`define BIT_PULLUP_N    7
`define BIT_EDGE_SEL    6
`define BIT_CHG_FLAG    0
`define BIT_EXT_FLAG    1
`define BIT_CHG_EN      3
`define BIT_LVP         0
`define BIT_RC_MODE     1
`define BIT_MASTER_CLEAR_IN_PIN    5
`define BIT_TMR_PIN     4
`define BIT_QUARTER_CLOCK_OUT_PIN    6
`define BIT_PGM_PIN     3
`define BIT_INT_PIN     0
`define ANALOG_MASK     8'h1F
`define CFG_ALL_DIG_A   4'h6
`define CFG_ALL_DIG_B   4'h7
`define RESP_OKAY       2'b00
`define RESP_SLVERR     2'b10
`endif

//--- dual_io_ports.v
// Two 8-bit general-purpose I/O ports with AXI4-Lite register access
//
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "gpio_defs.vh"
module dual_io_ports
(
  input  wire        CLOCK,
  input  wire        NRST,
  input  wire [11:0] AWADDR,
  input  wire        AWVALID,
  output reg         AWREADY,
  input  wire [31:0] WDATA,
  input  wire [3:0]  WSTRB,
  input  wire        WVALID,
  output reg         WREADY,
  output reg  [1:0]  BRESP,
  output reg         BVALID,
  input  wire        BREADY,
  input  wire [11:0] ARADDR,
  input  wire        ARVALID,
  output reg         ARREADY,
  output reg  [31:0] RDATA,
  output reg  [1:0]  RRESP,
  output reg         RVALID,
  input  wire        RREADY,
  input  wire [7:0]  PA_IN,
  output reg  [7:0]  PA_OUT,
  output reg  [7:0]  PA_OE,
  input  wire [7:0]  PB_IN,
  output reg  [7:0]  PB_OUT,
  output reg  [7:0]  PB_OE,
  output reg  [7:0]  PB_PULLUP,
  input  wire [7:0]  PERIPH_OVR_EN,
  input  wire [7:0]  PERIPH_OVR_IN,
  input  wire        SLEEP,
  output reg         WAKE,
  output reg         TIMER_EXT_CLOCK,
  output reg         ANALOG4_DIG,
  output reg         MASTER_CLEAR_IN
);

  // Byte address of a register index
  function hit;
    input [11:0] addr;
    input [7:0]  idx;
    begin
      hit = (addr == {2'b00, idx, 2'b00});
    end
  endfunction

  // Pins of the first port currently in analog mode
  function [7:0] analog_pins;
    input [3:0] pcfg;
    begin
      if (pcfg == `CFG_ALL_DIG_A || pcfg == `CFG_ALL_DIG_B)
        analog_pins = 8'h00;
      else
        analog_pins = `ANALOG_MASK;
    end
  endfunction

  reg  [7:0]  pa_s1_q;
  reg  [7:0]  pa_s2_q;
  reg  [7:0]  pb_s1_q;
  reg  [7:0]  pb_s2_q;
  reg  [7:0]  lat_a_q;
  reg  [7:0]  lat_b_q;
  reg  [7:0]  tris_a_q;
  reg  [7:0]  tris_b_q;
  reg  [7:0]  option_q;
  reg  [7:0]  conv_q;
  reg  [7:0]  interrupt_control_q;
  reg  [7:0]  interrupt_control_d;
  reg  [7:0]  sys_q;
  reg  [7:4]  snap_q;
  reg         int_prev_q;
  reg  [1:0]  div_q;
  reg  [11:0] aw_addr_q;
  reg         aw_held_q;
  reg  [31:0] w_data_q;
  reg  [3:0]  w_strb_q;
  reg         w_held_q;

  wire [7:0] ana_a;
  wire [7:0] rd_a;
  wire [7:0] dir_b;
  wire [7:0] rd_b;
  wire [7:0] tris_a_rd;
  wire       low_voltage_programming;
  wire       do_wr;
  wire       do_rd;
  wire [11:0] waddr;
  wire [7:0] wbyte;
  wire [3:0] mismatch;
  wire       edge_hit;
  wire       pb_access;
  reg  [7:0] rd_val;
  reg        rd_ok;
  reg        wr_ok;

  assign ana_a = analog_pins(conv_q[3:0]);
  assign low_voltage_programming = sys_q[`BIT_LVP];

  // Digital reads give pin levels, analog pins read zero
  assign rd_a = pa_s2_q & ~ana_a;
  assign tris_a_rd = tris_a_q | (8'h01 << `BIT_MASTER_CLEAR_IN_PIN);

  // Peripheral override, and the programming pin forced to input
  assign dir_b = ((tris_b_q & ~PERIPH_OVR_EN)
                 | (PERIPH_OVR_IN & PERIPH_OVR_EN)
                 | ({7'h00, low_voltage_programming} << `BIT_PGM_PIN));
  assign rd_b = pb_s2_q & ~({7'h00, low_voltage_programming} << `BIT_PGM_PIN);

  // Write proceeds once address and data are both held
  assign do_wr = aw_held_q && w_held_q && !BVALID;
  assign do_rd = ARVALID && ARREADY;
  assign waddr = aw_addr_q;

  // Unstrobed lane gives zero here; the latch write takes the sampled pin level instead
  assign wbyte = w_strb_q[0] ? w_data_q[7:0] : 8'h00;

  // Change detection on inputs among the upper four pins
  assign mismatch = (pb_s2_q[7:4] ^ snap_q) & dir_b[7:4];

  assign edge_hit = option_q[`BIT_EDGE_SEL]
                    ? (pb_s2_q[`BIT_INT_PIN] && !int_prev_q)
                    : (!pb_s2_q[`BIT_INT_PIN] && int_prev_q);

  assign pb_access = (do_wr && hit(waddr, `IDX_PORT_B))
                     || (do_rd && hit(ARADDR, `IDX_PORT_B));

  always @*
  begin
    rd_val = 8'h00;
    rd_ok = 1'b1;
    if (hit(ARADDR, `IDX_PORT_A))
      rd_val = rd_a;
    else if (hit(ARADDR, `IDX_PORT_B))
      rd_val = rd_b;
    else if (hit(ARADDR, `IDX_INTERRUPT_CONTROL))
      rd_val = interrupt_control_q;
    else if (hit(ARADDR, `IDX_OPTION))
      rd_val = option_q;
    else if (hit(ARADDR, `IDX_TRIS_A))
      rd_val = tris_a_rd;
    else if (hit(ARADDR, `IDX_TRIS_B))
      rd_val = tris_b_q;
    else if (hit(ARADDR, `IDX_CONV_CFG))
      rd_val = conv_q;
    else if (hit(ARADDR, `IDX_SYS_CFG))
      rd_val = sys_q;
    else
      rd_ok = 1'b0;
  end

  always @*
  begin
    wr_ok = hit(waddr, `IDX_PORT_A) || hit(waddr, `IDX_PORT_B)
            || hit(waddr, `IDX_INTERRUPT_CONTROL) || hit(waddr, `IDX_OPTION)
            || hit(waddr, `IDX_TRIS_A) || hit(waddr, `IDX_TRIS_B)
            || hit(waddr, `IDX_CONV_CFG) || hit(waddr, `IDX_SYS_CFG);
  end

  // Flags: hardware set wins over a software clear
  always @*
  begin
    interrupt_control_d = interrupt_control_q;
    if (do_wr && hit(waddr, `IDX_INTERRUPT_CONTROL) && w_strb_q[0])
      interrupt_control_d = w_data_q[7:0];
    if (|mismatch)
      interrupt_control_d[`BIT_CHG_FLAG] = 1'b1;
    if (edge_hit)
      interrupt_control_d[`BIT_EXT_FLAG] = 1'b1;
  end

  // Pin input synchronisers
  always @(posedge CLOCK)
  begin
    if (!NRST)
    begin
      pa_s1_q <= 8'h00;
      pa_s2_q <= 8'h00;
      pb_s1_q <= 8'h00;
      pb_s2_q <= 8'h00;
    end
    else
    begin
      pa_s1_q <= PA_IN;
      pa_s2_q <= pa_s1_q;
      pb_s1_q <= PB_IN;
      pb_s2_q <= pb_s1_q;
    end
  end

  // AXI4-Lite channel handshakes
  always @(posedge CLOCK)
  begin
    if (!NRST)
    begin
      AWREADY <= 1'b0;
      WREADY <= 1'b0;
      ARREADY <= 1'b0;
      BVALID <= 1'b0;
      BRESP <= `RESP_OKAY;
      RVALID <= 1'b0;
      RRESP <= `RESP_OKAY;
      RDATA <= 32'h0000_0000;
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      aw_addr_q <= 12'h000;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end
    else
    begin
      AWREADY <= !aw_held_q && !(AWVALID && AWREADY);
      WREADY <= !w_held_q && !(WVALID && WREADY);
      if (AWVALID && AWREADY)
      begin
        aw_held_q <= 1'b1;
        aw_addr_q <= AWADDR;
      end
      if (WVALID && WREADY)
      begin
        w_held_q <= 1'b1;
        w_data_q <= WDATA;
        w_strb_q <= WSTRB;
      end
      if (do_wr)
      begin
        BVALID <= 1'b1;
        BRESP <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (BVALID && BREADY)
      begin
        BVALID <= 1'b0;
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
      end
      ARREADY <= !RVALID && !do_rd;
      if (do_rd)
      begin
        RVALID <= 1'b1;
        RDATA <= {24'h00_0000, rd_val};
        RRESP <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (RVALID && RREADY)
        RVALID <= 1'b0;
    end
  end

  // Register file and change-detection state
  always @(posedge CLOCK)
  begin
    if (!NRST)
    begin
      lat_a_q <= 8'h00;
      lat_b_q <= 8'h00;
      tris_a_q <= `RST_TRIS;
      tris_b_q <= `RST_TRIS;
      option_q <= `RST_OPTION;
      conv_q <= `RST_CONV_CFG;
      interrupt_control_q <= `RST_INTERRUPT_CONTROL;
      sys_q <= `RST_SYS_CFG;
      snap_q <= 4'h0;
      int_prev_q <= 1'b0;
      div_q <= 2'b00;
    end
    else
    begin
      interrupt_control_q <= interrupt_control_d;
      int_prev_q <= pb_s2_q[`BIT_INT_PIN];
      div_q <= div_q + 2'b01;
      if (pb_access)
        snap_q <= pb_s2_q[7:4];
      if (do_wr)
      begin
        if (hit(waddr, `IDX_PORT_A))
          lat_a_q <= w_strb_q[0] ? wbyte : rd_a;
        if (hit(waddr, `IDX_PORT_B))
          lat_b_q <= w_strb_q[0] ? wbyte : rd_b;
        if (w_strb_q[0])
        begin
          if (hit(waddr, `IDX_OPTION))
            option_q <= w_data_q[7:0];
          if (hit(waddr, `IDX_TRIS_A))
            tris_a_q <= w_data_q[7:0];
          if (hit(waddr, `IDX_TRIS_B))
            tris_b_q <= w_data_q[7:0];
          if (hit(waddr, `IDX_CONV_CFG))
            conv_q <= w_data_q[7:0];
          if (hit(waddr, `IDX_SYS_CFG))
            sys_q <= w_data_q[7:0];
        end
      end
    end
  end

  // Pin drivers and side outputs, all registered
  always @(posedge CLOCK)
  begin
    if (!NRST)
    begin
      PA_OUT <= 8'h00;
      PA_OE <= 8'h00;
      PB_OUT <= 8'h00;
      PB_OE <= 8'h00;
      PB_PULLUP <= 8'h00;
      WAKE <= 1'b0;
      TIMER_EXT_CLOCK <= 1'b0;
      ANALOG4_DIG <= 1'b0;
      MASTER_CLEAR_IN <= 1'b0;
    end
    else
    begin
      PA_OUT <= lat_a_q;
      PA_OE <= ~tris_a_rd;
      if (sys_q[`BIT_RC_MODE])
      begin
        PA_OUT[`BIT_QUARTER_CLOCK_OUT_PIN] <= div_q[1];
        PA_OE[`BIT_QUARTER_CLOCK_OUT_PIN] <= 1'b1;
      end
      PB_OUT <= lat_b_q;
      PB_OE <= ~dir_b;
      PB_PULLUP <= option_q[`BIT_PULLUP_N] ? 8'h00 : dir_b;
      WAKE <= SLEEP && interrupt_control_q[`BIT_CHG_EN]
              && interrupt_control_q[`BIT_CHG_FLAG];
      TIMER_EXT_CLOCK <= pa_s2_q[`BIT_TMR_PIN];
      ANALOG4_DIG <= pa_s2_q[`BIT_TMR_PIN] && ana_a[`BIT_TMR_PIN];
      MASTER_CLEAR_IN <= pa_s2_q[`BIT_MASTER_CLEAR_IN_PIN];
    end
  end

endmodule

//--- io_chk.sv
// Port-level assertions for the dual I/O ports
`timescale 1ns/1ps
module io_chk (
  input wire        CLOCK,
  input wire        NRST,
  input wire        AWREADY,
  input wire        WREADY,
  input wire [1:0]  BRESP,
  input wire        BVALID,
  input wire        BREADY,
  input wire [31:0] RDATA,
  input wire        RVALID,
  input wire        RREADY,
  input wire [7:0]  PA_OE,
  input wire [7:0]  PB_OE,
  input wire [7:0]  PB_PULLUP,
  input wire [7:0]  PERIPH_OVR_EN,
  input wire [7:0]  PERIPH_OVR_IN,
  input wire        SLEEP,
  input wire        WAKE
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!NRST);
  pu_out_a:
    assert property ((PB_PULLUP & PB_OE) == 8'h00) else $error("pull-up on output");
  master_clear_in_dir_a:
    assert property (!PA_OE[5]) else $error("input-only pin driven");
  wake_slp_a:
    assert property (WAKE |-> $past(SLEEP)) else $error("wake while awake");
  ovr_dir_a:
    assert property (((PB_OE ^ ~$past(PERIPH_OVR_IN)) & $past(PERIPH_OVR_EN))
      == 8'h00) else $error("override ignored");
  pu_rst_a:
    assert property (disable iff (1'b0) !NRST |=> PB_PULLUP == 8'h00)
      else $error("pull-up in reset");
  b_hold_a:
    assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
      else $error("write response dropped");
  r_hold_a:
    assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
      else $error("read data dropped");
  wr_busy_a:
    assert property (BVALID |-> !AWREADY && !WREADY)
      else $error("write taken while busy");
endmodule
bind dual_io_ports io_chk u_chk (.*);

//--- io_board.sv
// Board model: pin levels seen by the port inputs
`timescale 1ns/1ps
module io_board (
  input  wire       clk,
  input  wire [7:0] pa_out,
  input  wire [7:0] pa_oe,
  input  wire [7:0] pb_out,
  input  wire [7:0] pb_oe,
  input  wire [7:0] pb_pu,
  input  wire [7:0] ext_a,
  input  wire [7:0] ext_b,
  input  wire [7:0] ext_en,
  output wire [7:0] pa_in,
  output wire [7:0] pb_in
);
  reg [7:0] flt_q = 8'h00;
  // Undriven pin without pull-up wanders every cycle
  always @(posedge clk)
  begin
    flt_q <= ~pb_in;
  end
  assign pa_in = (pa_oe & pa_out) | (~pa_oe & ext_a);
  assign pb_in = (pb_oe & pb_out) | (~pb_oe & ext_en & ext_b)
               | (~pb_oe & ~ext_en & (pb_pu | flt_q));
endmodule

//--- testbench.sv
// Self-checking bench for the dual I/O ports
`timescale 1ns/1ps
`include "gpio_defs.vh"
module testbench;
  localparam [1:0] OK = `RESP_OKAY;
  localparam [1:0] ER = `RESP_SLVERR;
  reg         CLOCK = 0, NRST = 0, SLEEP = 0;
  reg         AWVALID = 0, WVALID = 0, BREADY = 0, ARVALID = 0, RREADY = 0;
  reg  [11:0] AWADDR = 0, ARADDR = 0;
  reg  [31:0] WDATA = 0;
  reg  [3:0]  WSTRB = 4'h1;
  reg  [7:0]  PERIPH_OVR_EN = 0, PERIPH_OVR_IN = 0, d, ea = 0, eb = 0;
  reg  [7:0]  een = 8'hFF;
  wire        AWREADY, WREADY, BVALID, ARREADY, RVALID, WAKE;
  wire        TIMER_EXT_CLOCK, ANALOG4_DIG, MASTER_CLEAR_IN;
  wire [1:0]  BRESP, RRESP;
  wire [31:0] RDATA;
  wire [7:0]  PA_IN, PA_OUT, PA_OE, PB_IN, PB_OUT, PB_OE, PB_PULLUP;
  reg  [33:0] rq[$];
  reg  [1:0]  bq[$];
  integer     bad_count = 0, n_compared = 0, i;
  always #5 CLOCK = ~CLOCK;
  dual_io_ports u_dut (.*);
  io_board u_brd (.clk(CLOCK), .pa_out(PA_OUT), .pa_oe(PA_OE),
    .pb_out(PB_OUT), .pb_oe(PB_OE), .pb_pu(PB_PULLUP), .ext_a(ea),
    .ext_b(eb), .ext_en(een), .pa_in(PA_IN), .pb_in(PB_IN));
  task chk(input [33:0] g, input [33:0] e);
  begin
    n_compared = n_compared + 1;
    if (g !== e)
    begin
      bad_count = bad_count + 1;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  end
  endtask
  task pk(input [7:0] g, input [7:0] e);
    chk({26'h0, g}, {26'h0, e});
  endtask
  // One bus transfer; the monitor judges the answer
  task go(input w, input [7:0] a, input [7:0] v, input [1:0] r);
  begin
    if (w) bq.push_back(r);
    else rq.push_back({r, 24'h00_0000, v});
    @(posedge CLOCK);
    AWADDR <= {2'h0, a, 2'h0};
    ARADDR <= {2'h0, a, 2'h0};
    WDATA <= {24'h00_0000, v};
    {AWVALID, WVALID, BREADY} <= {3{w}};
    {ARVALID, RREADY} <= {2{~w}};
    do
    begin
      @(posedge CLOCK);
      if (AWREADY) AWVALID <= 1'h0;
      if (WREADY) WVALID <= 1'h0;
      if (ARREADY) ARVALID <= 1'h0;
    end
    while (!(w ? BVALID : RVALID));
    {BREADY, RREADY} <= 2'h0;
  end
  endtask
  always @(posedge CLOCK)
  begin
    if (RVALID && RREADY) chk({RRESP, RDATA}, rq.pop_front());
    if (BVALID && BREADY) chk({32'h0, BRESP}, {32'h0, bq.pop_front()});
  end
  task test_done;
  begin
    $display("compares %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  end
  endtask
  initial
  begin
    #100000;
    bad_count = bad_count + 1;
    test_done;
  end
  initial
  begin
    i = $urandom(32'h74b3796c);
    ea = $urandom;
    eb = $urandom;
    d = $urandom;
    repeat (5) @(posedge CLOCK);
    NRST <= 1'h1;
    repeat (4) @(posedge CLOCK);
    pk({5'h0, TIMER_EXT_CLOCK, ANALOG4_DIG, MASTER_CLEAR_IN},
       {5'h0, ea[4], ea[4], ea[5]});
    pk(PB_PULLUP, 8'h00);
    go(0, `IDX_OPTION, `RST_OPTION, OK);
    go(0, `IDX_TRIS_A, `RST_TRIS, OK);
    go(0, `IDX_TRIS_B, `RST_TRIS, OK);
    go(0, `IDX_PORT_A, ea & 8'hE0, OK);
    go(1, 8'h40, d, ER);
    go(0, 8'h40, 8'h00, ER);
    go(1, `IDX_CONV_CFG, {4'h0, `CFG_ALL_DIG_A}, OK);
    go(1, `IDX_PORT_A, d, OK);
    go(1, `IDX_TRIS_A, 8'h00, OK);
    go(0, `IDX_TRIS_A, 8'h20, OK);
    pk(PA_OE, 8'hDF);
    pk(PA_OUT, d);
    go(0, `IDX_PORT_A, (d & 8'hDF) | (ea & 8'h20), OK);
    go(1, `IDX_TRIS_A, 8'hFF, OK);
    repeat (3) @(posedge CLOCK);
    WSTRB <= 4'h0;
    go(1, `IDX_PORT_A, ~d, OK);
    WSTRB <= 4'h1;
    go(1, `IDX_TRIS_A, 8'h00, OK);
    pk(PA_OUT, ea);
    go(1, `IDX_SYS_CFG, 8'h03, OK);
    repeat (2) @(posedge CLOCK);
    d = PA_OUT;
    repeat (2) @(posedge CLOCK);
    pk(PA_OUT ^ d, 8'h40);
    go(1, `IDX_OPTION, 8'h7F, OK);
    go(1, `IDX_TRIS_B, 8'hF0, OK);
    @(posedge CLOCK);
    pk(PB_OE, 8'h07);
    pk(PB_PULLUP, 8'hF8);
    go(1, `IDX_SYS_CFG, 8'h00, OK);
    een <= 8'h00;
    repeat (3) @(posedge CLOCK);
    pk(PB_PULLUP, 8'hF0);
    go(0, `IDX_PORT_B, 8'hF0, OK);
    een <= 8'hFF;
    eb <= 8'hD0;
    repeat (3) @(posedge CLOCK);
    go(0, `IDX_PORT_B, 8'hD0, OK);
    go(1, `IDX_INTERRUPT_CONTROL, 8'h08, OK);
    go(1, `IDX_TRIS_B, 8'h70, OK);
    repeat (3) @(posedge CLOCK);
    go(0, `IDX_INTERRUPT_CONTROL, 8'h08, OK);
    SLEEP <= 1'h1;
    eb <= 8'h90;
    repeat (5) @(posedge CLOCK);
    pk({7'h0, WAKE}, 8'h01);
    go(1, `IDX_INTERRUPT_CONTROL, 8'h08, OK);
    go(0, `IDX_INTERRUPT_CONTROL, 8'h09, OK);
    go(0, `IDX_PORT_B, 8'h10, OK);
    go(1, `IDX_INTERRUPT_CONTROL, 8'h00, OK);
    go(0, `IDX_INTERRUPT_CONTROL, 8'h00, OK);
    SLEEP <= 1'h0;
    PERIPH_OVR_EN <= 8'h03;
    PERIPH_OVR_IN <= 8'h01;
    repeat (2) @(posedge CLOCK);
    pk(PB_OE, 8'h8E);
    for (i = 1; i >= 0; i = i - 1)
    begin
      go(1, `IDX_OPTION, {1'h0, i[0], 6'h3F}, OK);
      go(1, `IDX_INTERRUPT_CONTROL, 8'h00, OK);
      eb[0] <= 1'h1;
      repeat (4) @(posedge CLOCK);
      go(0, `IDX_INTERRUPT_CONTROL, {6'h0, i[0], 1'h0}, OK);
      go(1, `IDX_INTERRUPT_CONTROL, 8'h00, OK);
      eb[0] <= 1'h0;
      repeat (4) @(posedge CLOCK);
      go(0, `IDX_INTERRUPT_CONTROL, {6'h0, ~i[0], 1'h0}, OK);
    end
    test_done;
  end
endmodule
